// file: hdl/dac_ctrl_pkg.sv
// Purpose: Shared constants for the dual-channel DAC control logic
// Assumes: 24-bit input words arrive already framed from the serial port
// Notes: Exit time is kept in ns with its cycle count derived from the clock period; the power-on hold is given in cycles
package dac_ctrl_pkg;

    // ==========================================================
    // Input word layout
    localparam int WORD_W = 24;
    localparam int DATA_W = 16;
    localparam int RSVD_BIT = 23;
    localparam int CMD_HI = 21;
    localparam int CMD_LO = 19;
    localparam int ADDR_HI = 18;
    localparam int ADDR_LO = 16;
    localparam int PM_HI = 5;
    localparam int PM_LO = 4;
    localparam int SEL_B_BIT = 1;
    localparam int SEL_A_BIT = 0;
    localparam int RST_SCOPE_BIT = 0;
    localparam int REF_BIT = 0;

    // ==========================================================
    // Command and address codes
    localparam logic [2:0] CMD_POWER = 3'h4;
    localparam logic [2:0] CMD_SWRESET = 3'h5;
    localparam logic [2:0] CMD_MASK = 3'h6;
    localparam logic [2:0] CMD_REF = 3'h7;
    localparam logic [2:0] ADDR_A = 3'h0;
    localparam logic [2:0] ADDR_B = 3'h1;
    localparam logic [2:0] ADDR_BOTH = 3'h7;

    // ==========================================================
    // Power modes
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_1K = 2'h1;
    localparam logic [1:0] PM_100K = 2'h2;
    localparam logic [1:0] PM_TRISTATE = 2'h3;

    // ==========================================================
    // Reset values
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic REF_RESET = 1'h0;
    localparam logic [DATA_W-1:0] ZERO_SCALE = 16'h0000;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int EXIT_TIME_NS = 4000;
    localparam int EXIT_CYCLES_INT = (EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] EXIT_CYCLES = 6'(EXIT_CYCLES_INT);
    localparam logic [4:0] POR_HOLD_CYCLES = 5'h10;

endpackage

// file: hdl/dac_ctrl.sv
// Purpose: Command decode, load-strobe, clear and power-down control of a dual DAC
// Assumes: Link side delivers whole 24-bit words with a one-cycle valid on LINK_CLK_IN
// Notes: Pins are sampled through two flops, so the clear edge is seen 2-3 clocks late
`timescale 1ns/1ns
`default_nettype none

module dac_ctrl
    import dac_ctrl_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic LINK_CLK_IN,
    input wire logic WORD_VALID_IN,
    input wire logic [WORD_W-1:0] WORD_IN,
    input wire logic LOAD_STROBE_N_IN,
    input wire logic CLEAR_N_IN,
    output logic WRITE_ABORT_OUT,
    output logic HS_EXIT_OUT,
    output logic [DATA_W-1:0] DAC_A_OUT,
    output logic [DATA_W-1:0] DAC_B_OUT,
    output logic [1:0] POWER_MODE_A_OUT,
    output logic [1:0] POWER_MODE_B_OUT,
    output logic OUT_READY_A_OUT,
    output logic OUT_READY_B_OUT,
    output logic REF_ON_OUT,
    output logic ZERO_HOLD_OUT,
    output logic CLEAR_MODE_OUT
);

    function automatic logic addr_hit(input logic [2:0] addr, input logic [2:0] own);
        addr_hit = (addr == own) || (addr == ADDR_BOTH);
    endfunction
    // ==========================================================
    // Link domain: word capture and abort
    logic ab_meta;
    logic ab_sync;
    logic ab_prev;
    logic hs_exit;
    logic word_tgl;
    logic [WORD_W-1:0] held_word;
    logic clear_hold;
    wire link_take = WORD_VALID_IN && !ab_sync;

    always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            ab_meta <= 1'b0;
            ab_sync <= 1'b0;
            ab_prev <= 1'b0;
            hs_exit <= 1'b0;
        end
        else
        begin
            ab_meta <= clear_hold;
            ab_sync <= ab_meta;
            ab_prev <= ab_sync;
            hs_exit <= ab_sync && !ab_prev;
        end
    end

    // Word is held until the next one, long after the toggle has crossed
    always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            word_tgl <= 1'b0;
            held_word <= 24'h000000;
        end
        else if (link_take)
        begin
            word_tgl <= !word_tgl;
            held_word <= WORD_IN;
        end
    end
    assign WRITE_ABORT_OUT = ab_sync;
    assign HS_EXIT_OUT = hs_exit;
    // ==========================================================
    // Main domain: pin and toggle synchronisers
    logic ls_meta;
    logic ls_sync;
    logic cl_meta;
    logic cl_sync;
    logic cl_prev;
    logic tg_meta;
    logic tg_sync;
    logic tg_prev;
    logic [4:0] por_cnt;
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            ls_meta <= 1'b1;
            ls_sync <= 1'b1;
            cl_meta <= 1'b1;
            cl_sync <= 1'b1;
            cl_prev <= 1'b1;
            tg_meta <= 1'b0;
            tg_sync <= 1'b0;
            tg_prev <= 1'b0;
        end
        else if (CE_IN)
        begin
            ls_meta <= LOAD_STROBE_N_IN;
            ls_sync <= ls_meta;
            cl_meta <= CLEAR_N_IN;
            cl_sync <= cl_meta;
            cl_prev <= cl_sync;
            tg_meta <= word_tgl;
            tg_sync <= tg_meta;
            tg_prev <= tg_sync;
        end
    end

    // Power-on hold: pins are not trusted while supplies settle
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            por_cnt <= POR_HOLD_CYCLES;
        else if (CE_IN && por_cnt != 5'h00)
            por_cnt <= por_cnt - 5'h01;
    end
    // ==========================================================
    // Decode
    wire por_busy = (por_cnt != 5'h00);
    wire clear_low = !cl_sync && !por_busy;
    wire clear_fall = cl_prev && !cl_sync && !por_busy;
    wire strobe_low = !ls_sync && !por_busy && !clear_low;
    wire word_new = tg_sync ^ tg_prev;
    wire word_ok = CE_IN && word_new && !clear_low;
    // Reserved top bit is not checked, the master keeps it clear
    wire [2:0] word_cmd = held_word[CMD_HI:CMD_LO];
    wire [2:0] word_addr = held_word[ADDR_HI:ADDR_LO];
    wire [DATA_W-1:0] word_data = held_word[DATA_W-1:0];
    wire cmd_write = word_ok && !word_cmd[2];
    wire cmd_power = word_ok && (word_cmd == CMD_POWER);
    wire cmd_swrst = word_ok && (word_cmd == CMD_SWRESET);
    wire cmd_mask = word_ok && (word_cmd == CMD_MASK);
    wire cmd_ref = word_ok && (word_cmd == CMD_REF);
    wire full_rst = cmd_swrst && word_data[RST_SCOPE_BIT];
    wire [1:0] new_pm = word_data[PM_HI:PM_LO];
    logic [DATA_W-1:0] in_reg [2];
    logic [DATA_W-1:0] dac_reg [2];
    logic [1:0] pending;
    logic [1:0] load_mask;
    logic [1:0] pmode [2];
    logic [5:0] exit_cnt [2];
    logic ref_on;
    logic first_done;
    logic clear_mode;
    wire [1:0] wr_sel = {cmd_write && addr_hit(word_addr, ADDR_B),
        cmd_write && addr_hit(word_addr, ADDR_A)};
    wire [1:0] pm_wr = {cmd_power && word_data[SEL_B_BIT],
        cmd_power && word_data[SEL_A_BIT]};
    wire zero_data = clear_fall || cmd_swrst;
    // A channel moves only when its input was written since its last update
    wire [1:0] do_xfer = pending & (load_mask | {2{strobe_low}})
        & {2{!zero_data}};
    wire [1:0] to_normal = {
        pmode[1] != PM_NORMAL && ((pm_wr[1] && new_pm == PM_NORMAL) || full_rst),
        pmode[0] != PM_NORMAL && ((pm_wr[0] && new_pm == PM_NORMAL) || full_rst)};
    // ==========================================================
    // Data path; power mode never touches the DAC registers
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            in_reg <= '{ZERO_SCALE, ZERO_SCALE};
            dac_reg <= '{ZERO_SCALE, ZERO_SCALE};
        end
        else if (CE_IN)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (clear_fall)
                    in_reg[c] <= ZERO_SCALE;
                else if (wr_sel[c])
                    in_reg[c] <= word_data;
                if (zero_data)
                    dac_reg[c] <= ZERO_SCALE;
                else if (do_xfer[c])
                    dac_reg[c] <= in_reg[c];
            end
        end
    end
    // New data wins over a transfer in the same cycle; it stays pending until the next transfer, clear edge or software reset
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            pending <= 2'h0;
        else if (CE_IN)
            pending <= zero_data ? 2'h0 : (wr_sel | (pending & ~do_xfer));
    end
    // ==========================================================
    // Control registers
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            load_mask <= MASK_RESET;
            ref_on <= REF_RESET;
        end
        else if (CE_IN)
        begin
            if (full_rst)
                load_mask <= MASK_RESET;
            else if (cmd_mask)
                load_mask <= word_data[SEL_B_BIT:SEL_A_BIT];
            if (full_rst)
                ref_on <= REF_RESET;
            else if (cmd_ref)
                ref_on <= word_data[REF_BIT];
        end
    end
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            pmode <= '{PM_NORMAL, PM_NORMAL};
            exit_cnt <= '{6'h00, 6'h00};
        end
        else if (CE_IN)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (full_rst)
                    pmode[c] <= PM_NORMAL;
                else if (pm_wr[c])
                    pmode[c] <= new_pm;
                if (to_normal[c])
                    exit_cnt[c] <= EXIT_CYCLES;
                else if (exit_cnt[c] != 6'h00)
                    exit_cnt[c] <= exit_cnt[c] - 6'h01;
            end
        end
    end
    // ==========================================================
    // Status: clear mode and power-up zero hold
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            first_done <= 1'b0;
            clear_mode <= 1'b0;
            clear_hold <= 1'b0;
        end
        else if (CE_IN)
        begin
            clear_hold <= clear_low;
            if (word_ok)
                first_done <= 1'b1;
            // Clear edge beats the end of a write arriving in the same cycle
            if (clear_fall)
                clear_mode <= 1'b1;
            else if (word_ok)
                clear_mode <= 1'b0;
        end
    end

    // DAC outputs are zero before the first accepted word of any command regardless of register state
    assign DAC_A_OUT = first_done ? dac_reg[0] : ZERO_SCALE;
    assign DAC_B_OUT = first_done ? dac_reg[1] : ZERO_SCALE;
    assign POWER_MODE_A_OUT = pmode[0];
    assign POWER_MODE_B_OUT = pmode[1];
    assign OUT_READY_A_OUT = (pmode[0] == PM_NORMAL) && (exit_cnt[0] == 6'h00);
    assign OUT_READY_B_OUT = (pmode[1] == PM_NORMAL) && (exit_cnt[1] == 6'h00);
    assign REF_ON_OUT = ref_on;
    assign ZERO_HOLD_OUT = !first_done;
    assign CLEAR_MODE_OUT = clear_mode;
    // ==========================================================
    // Checks
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    AST_MASK_SYNC_XFER: assert property (
        (CE_IN && pending[0] && load_mask[0] && !zero_data)
        |=> dac_reg[0] == $past(in_reg[0]))
        else $error("masked channel did not update");
    AST_ASYNC_HOLD: assert property (
        (CE_IN && !load_mask[1] && !strobe_low && !zero_data) |=> $stable(dac_reg[1]))
        else $error("strobe-controlled channel changed without strobe");
    AST_STROBE_XFER: assert property (
        (CE_IN && pending[1] && strobe_low && !zero_data)
        |=> dac_reg[1] == $past(in_reg[1]) && !pending[1] || $past(wr_sel[1]))
        else $error("strobe low did not transfer");
    AST_NO_REPEAT: assert property (
        (CE_IN && !pending[0] && !zero_data) |=> $stable(dac_reg[0]))
        else $error("transfer without new data");
    AST_MASK_SETUP: assert property (
        (cmd_mask && !full_rst) |=> load_mask == $past(word_data[1:0]))
        else $error("mask not loaded");
    AST_PM_KEEP: assert property (
        (cmd_power && !word_data[SEL_A_BIT]) |=> $stable(pmode[0]))
        else $error("unselected channel power changed");
    AST_PM_SET: assert property (
        (pm_wr[1]) |=> pmode[1] == $past(new_pm))
        else $error("power mode not taken");
    AST_EXIT_LATENCY: assert property (
        (CE_IN && to_normal[0]) |=> !OUT_READY_A_OUT [*8])
        else $error("output ready too early");
    AST_EXIT_DONE: assert property (
        $rose(OUT_READY_A_OUT) |-> $past(exit_cnt[0]) == 6'h01 || $past(pmode[0]) != PM_NORMAL)
        else $error("exit count wrong");
    AST_CLEAR_ZERO: assert property (
        (CE_IN && clear_fall)
        |=> dac_reg[0] == ZERO_SCALE && dac_reg[1] == ZERO_SCALE && in_reg[0] == ZERO_SCALE)
        else $error("clear did not zero registers");
    AST_CLEAR_BLOCKS: assert property (
        (CE_IN && clear_low && load_mask == 2'h0 && !zero_data) |=> $stable(dac_reg[0]))
        else $error("strobe acted during clear");
    AST_POR_IGNORE: assert property (
        (por_busy) |=> !clear_mode)
        else $error("clear acted during power-on hold");
    AST_SWRST_SCOPE: assert property (
        (cmd_swrst && !word_data[RST_SCOPE_BIT])
        |=> $stable(load_mask) && $stable(ref_on) && dac_reg[1] == ZERO_SCALE)
        else $error("partial reset scope wrong");
    AST_REF_SET: assert property (
        (cmd_ref) |=> ref_on == $past(word_data[REF_BIT]))
        else $error("reference state not taken");
    AST_LEAVE_CLEAR: assert property (
        (word_ok && !clear_fall) |=> !clear_mode && !ZERO_HOLD_OUT)
        else $error("clear mode not left on write");
    AST_ABORT_DROP: assert property (@(posedge LINK_CLK_IN) disable iff (!RSTN_IN)
        (ab_sync) |=> $stable(word_tgl))
        else $error("word taken during abort");

    COV_MASKED_WRITE: cover property (cmd_write && load_mask == 2'h3);
    COV_STROBE_XFER: cover property (CE_IN && pending[0] && strobe_low);
    COV_CLEAR_THEN_WRITE: cover property (clear_fall ##[1:500] word_ok);
    COV_POWER_EXIT: cover property (to_normal[1] ##[1:60] OUT_READY_B_OUT);

endmodule

`default_nettype wire

// file: sim/word_source.sv
// Purpose: Far-side model that frames 24-bit command words onto the link
// Assumes: One word per request; link clock runs only while a frame is sent
// Notes: Idle data shows the inverse of the last word so stale values never match
`timescale 1ns/1ns
`default_nettype none

module word_source
(
    input wire logic req_in,
    input wire logic [23:0] word_in,
    output logic done_out,
    output logic link_clk_out,
    output logic word_valid_out,
    output logic [23:0] word_out
);
    logic [23:0] last;

    // ==========================================================
    // Frame generator
    initial
    begin
        link_clk_out = 1'b0;
        word_valid_out = 1'b0;
        word_out = 24'hFFFFFF;
        done_out = 1'b0;
        last = 24'h000000;
        #37;
        forever
        begin
            wait (req_in === 1'b1);
            // 24 serial clocks per word; valid only on the last one
            for (int i = 0; i < 24; i++)
            begin
                word_valid_out = (i == 23);
                word_out = (i == 23) ? {1'b0, word_in[22:0]} : ~last;
                #62 link_clk_out = 1'b1;
                #63 link_clk_out = 1'b0;
            end
            last = word_out;
            word_valid_out = 1'b0;
            word_out = ~last;
            done_out = 1'b1;
            wait (req_in === 1'b0);
            done_out = 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: sim/dual_dac_control_commands_tb_top.sv
// Purpose: Self-checking bench for the dual DAC command and pin control
// Assumes: Words arrive through the word_source model on a 125 ns link clock
// Notes: Expectations come from the bench's own model of masks and modes
`timescale 1ns/1ns
`default_nettype none

module dual_dac_control_commands_tb_top;
    import dac_ctrl_pkg::*;

    logic mclk, rstn, ce, load_n, clear_n, req;
    logic [WORD_W-1:0] word;
    wire logic link_clk, word_valid, done, write_abort, hs_exit;
    wire logic ready_a, ready_b, ref_on, zero_hold, clear_mode;
    wire logic [WORD_W-1:0] link_word;
    wire logic [DATA_W-1:0] dac_a, dac_b;
    wire logic [1:0] mode_a, mode_b;
    int errors, total_checks, hs_count, abort_seen;
    logic [DATA_W-1:0] da, db, d;
    logic [1:0] ma, mb, sel, m;

    word_source i_src (.req_in(req), .word_in(word), .done_out(done),
        .link_clk_out(link_clk), .word_valid_out(word_valid), .word_out(link_word));

    dac_ctrl i_dut (.MCLK_IN(mclk), .RSTN_IN(rstn), .CE_IN(ce), .LINK_CLK_IN(link_clk),
        .WORD_VALID_IN(word_valid), .WORD_IN(link_word), .LOAD_STROBE_N_IN(load_n),
        .CLEAR_N_IN(clear_n), .WRITE_ABORT_OUT(write_abort), .HS_EXIT_OUT(hs_exit),
        .DAC_A_OUT(dac_a), .DAC_B_OUT(dac_b), .POWER_MODE_A_OUT(mode_a),
        .POWER_MODE_B_OUT(mode_b), .OUT_READY_A_OUT(ready_a), .OUT_READY_B_OUT(ready_b),
        .REF_ON_OUT(ref_on), .ZERO_HOLD_OUT(zero_hold), .CLEAR_MODE_OUT(clear_mode));

    // ==========================================================
    // Clock and link-side monitors
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge link_clk)
    begin
        if (hs_exit === 1'b1)
            hs_count++;
        if (write_abort === 1'b1)
            abort_seen = 1;
    end

    // ==========================================================
    // Helpers
    task automatic end_sim;
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        total_checks++;
        if (seen !== want)
        begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask

    function automatic logic [1:0] pick(input logic s, input logic [1:0] nw, input logic [1:0] od);
        return s ? nw : od;
    endfunction

    // Byte-select bit and unused fields are randomised: the device must ignore them
    task automatic send(input logic [2:0] c, input logic [2:0] a, input logic [15:0] dd);
        int k;
        @(posedge mclk);
        word <= {1'b0, 1'($urandom), c, a, dd};
        req <= 1'b1;
        for (k = 0; k < 100 && done !== 1'b1; k++)
            @(posedge mclk);
        if (k == 100)
        begin
            errors++;
            $display("CHECK FAILED at %0t: link frame never finished", $time);
            end_sim;
        end
        req <= 1'b0;
        cycles(10);
    endtask

    task automatic strobe;
        @(posedge mclk);
        load_n <= 1'b0;
        cycles(3);
        load_n <= 1'b1;
        cycles(6);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h5F43));
        {errors, total_checks, hs_count, abort_seen} = '0;
        ce = 1'b1;
        rstn = 1'b0;
        load_n = 1'b1;
        clear_n = 1'b1;
        req = 1'b0;
        word = '0;
        cycles(10);
        rstn <= 1'b1;
        cycles(2);
        clear_n <= 1'b0;
        cycles(4);
        clear_n <= 1'b1;
        check(DATA_W'(clear_mode), 16'h0000);
        cycles(16);
        check(DATA_W'(zero_hold), 16'h0001);
        check(DATA_W'(ref_on), 16'h0000);
        da = 16'($urandom);
        send(3'h0, ADDR_A, da);
        check(dac_a, 16'h0000);
        check(DATA_W'(zero_hold), 16'h0000);
        db = 16'($urandom);
        send(3'h0, ADDR_B, db);
        strobe();
        check(dac_a, da);
        check(dac_b, db);
        send(CMD_MASK, 3'($urandom), {14'($urandom), 2'h1});
        d = 16'($urandom);
        send(3'h0, ADDR_BOTH, d);
        check(dac_a, d);
        check(dac_b, db);
        strobe();
        check(dac_b, d);
        da = d;
        {ma, mb} = '0;
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i);
            sel = (i == 3) ? 2'h3 : 2'($urandom);
            send(CMD_POWER, 3'($urandom), {10'($urandom), m, 2'($urandom), sel});
            ma = pick(sel[0], m, ma);
            mb = pick(sel[1], m, mb);
            check(DATA_W'(mode_a), DATA_W'(ma));
            check(DATA_W'(mode_b), DATA_W'(mb));
            check(dac_a, da);
        end
        send(CMD_POWER, 3'h0, {10'h000, PM_NORMAL, 4'h3});
        check(DATA_W'(ready_a), 16'h0000);
        cycles(EXIT_CYCLES_INT);
        check(DATA_W'(ready_a), 16'h0001);
        check(DATA_W'(ready_b), 16'h0001);
        send(CMD_REF, 3'($urandom), {15'($urandom), 1'b1});
        check(DATA_W'(ref_on), 16'h0001);
        send(CMD_SWRESET, 3'($urandom), {15'($urandom), 1'b0});
        check(dac_a, 16'h0000);
        check(dac_b, 16'h0000);
        check(DATA_W'(ref_on), 16'h0001);
        send(CMD_POWER, 3'h0, {10'h000, PM_1K, 4'h1});
        send(CMD_SWRESET, 3'($urandom), {15'($urandom), 1'b1});
        check(DATA_W'(ref_on), 16'h0000);
        check(DATA_W'(mode_a), 16'h0000);
        da = 16'($urandom) | 16'h0001;
        send(3'h0, ADDR_A, da);
        check(dac_a, 16'h0000);
        strobe();
        check(dac_a, da);
        // Clear: outputs zeroed, strobes and words refused while low
        @(posedge mclk);
        clear_n <= 1'b0;
        cycles(6);
        check(dac_a, 16'h0000);
        check(DATA_W'(clear_mode), 16'h0001);
        send(3'h0, ADDR_B, 16'($urandom) | 16'h0001);
        strobe();
        check(dac_b, 16'h0000);
        check(16'(abort_seen), 16'h0001);
        check(16'(hs_count), 16'h0001);
        @(posedge mclk);
        clear_n <= 1'b1;
        cycles(6);
        d = 16'($urandom);
        send(3'h0, ADDR_A, d);
        check(DATA_W'(clear_mode), 16'h0000);
        strobe();
        check(dac_a, d);
        check(dac_b, 16'h0000);
        da = d;
        db = 16'h0000;
        // Random masks against both-channel writes
        repeat (6)
        begin
            m = 2'($urandom);
            send(CMD_MASK, 3'($urandom), {14'($urandom), m});
            d = 16'($urandom);
            send(3'h0, ADDR_BOTH, d);
            check(dac_a, m[0] ? d : da);
            check(dac_b, m[1] ? d : db);
            strobe();
            check(dac_a, d);
            check(dac_b, d);
            {da, db} = {d, d};
        end
        // Clock enable low freezes the main domain; a word waits until it returns
        send(CMD_MASK, 3'h0, 16'h0003);
        @(posedge mclk);
        ce <= 1'b0;
        d = ~da;
        send(3'h0, ADDR_A, d);
        check(dac_a, da);
        @(posedge mclk);
        ce <= 1'b1;
        cycles(6);
        check(dac_a, d);
        end_sim;
    end
endmodule

`default_nettype wire
